// ==== design/isf_format.v ====
// Purpose: Operand format unit: integer loads, leading sign decimal strings
// Assumes: Byte memory port on the same clock, one transfer per req and ack cycle
// Notes: Octaword width holds any 31 digit decimal value without overflow
`timescale 1ns/1ns
`include "isf_consts.vh"

module isf_format (
  input wire clk,
  input wire sys_rst,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [2:0] cmd_size,
  input wire cmd_signed,
  input wire cmd_sub,
  input wire [31:0] cmd_addr,
  input wire [5:0] cmd_len,
  input wire cmd_neg,
  input wire [123:0] cmd_bcd,
  input wire [31:0] cmd_a,
  input wire [31:0] cmd_b,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  output reg busy,
  output reg done,
  output reg inv_err,
  output reg res_neg,
  output reg res_ovf,
  output reg res_lt,
  output reg res_eq,
  output reg [127:0] result,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [7:0] mem_wdata
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RD_INT = 3'h1;
  localparam ST_RD_SIGN = 3'h2;
  localparam ST_RD_DIG = 3'h3;
  localparam ST_WR_SIGN = 3'h4;
  localparam ST_WR_DIG = 3'h5;
  localparam ST_FIN = 3'h6;

  reg [2:0] state;
  reg [2:0] op;
  reg [2:0] size;
  reg sgn;
  reg neg;
  reg [5:0] remain;
  reg [3:0] idx;
  reg [127:0] acc;
  reg [123:0] bcd;

  wire [31:0] ar_sum;
  wire ar_err;
  wire ar_lt;
  wire ar_eq;

  // Byte, word and longword add, subtract and compare
  isf_arith u_arith (
    .a(cmd_a),
    .b(cmd_b),
    .size(cmd_size[1:0]),
    .is_signed(cmd_signed),
    .sub(cmd_sub),
    .sum(ar_sum),
    .range_err(ar_err),
    .lt(ar_lt),
    .eq(ar_eq)
  );

  // Sign bit position for the latched size, byte count for the command size
  reg [6:0] top;
  reg [5:0] nbytes;
  always @* begin
    case (size)
      `ISF_SZ_BYTE: top = `ISF_TOP_BYTE;
      `ISF_SZ_WORD: top = `ISF_TOP_WORD;
      `ISF_SZ_LONG: top = `ISF_TOP_LONG;
      `ISF_SZ_QUAD: top = `ISF_TOP_QUAD;
      default: top = `ISF_TOP_OCTA;
    endcase
  end

  always @* begin
    case (cmd_size)
      `ISF_SZ_BYTE: nbytes = 6'h01;
      `ISF_SZ_WORD: nbytes = 6'h02;
      `ISF_SZ_LONG: nbytes = 6'h04;
      `ISF_SZ_QUAD: nbytes = 6'h08;
      default: nbytes = 6'h10;
    endcase
  end

  // Extension of the loaded integer to full width
  reg [127:0] next_ext;
  reg ext_sign;
  integer i;
  always @* begin
    ext_sign = sgn & acc[top];
    for (i = 0; i < 128; i = i + 1) begin
      next_ext[i] = (i <= top) ? acc[i] : ext_sign;
    end
  end

  // Digit check on the command word, only within the given count
  reg bcd_bad;
  integer j;
  always @* begin
    bcd_bad = 1'b0;
    for (j = 0; j < 31; j = j + 1) begin
      if ((j < cmd_len) && (cmd_bcd[j*4 +: 4] > `ISF_DIGIT_MAX)) begin
        bcd_bad = 1'b1;
      end
    end
  end

  // Next digit to write, most significant first
  wire [5:0] dig_sel = (state == ST_WR_SIGN) ? (remain - 6'h01) : (remain - 6'h02);
  wire [123:0] bcd_shift = bcd >> {dig_sel, 2'b00};
  wire [7:0] next_digit = {`ISF_DIGIT_ZONE, bcd_shift[3:0]};

  // Read byte checks
  wire sign_pos = (mem_rdata == `ISF_SIGN_PLUS) || (mem_rdata == `ISF_SIGN_BLANK);
  wire sign_neg = (mem_rdata == `ISF_SIGN_MINUS);
  wire dig_ok = (mem_rdata >= `ISF_DIGIT_LO) && (mem_rdata <= `ISF_DIGIT_HI);
  wire [127:0] acc_x10 = (acc << 3) + (acc << 1);
  wire [127:0] next_acc_dig = acc_x10 + {124'h0, mem_rdata[3:0]};
  wire [127:0] next_acc_int = acc | ({120'h0, mem_rdata} << {idx, 3'b000});
  wire [127:0] neg_acc = ~acc + 128'h1;

  // Sequencer; an error ends the command at once with a zero result
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op <= 3'h0;
      size <= 3'h0;
      sgn <= 1'b0;
      neg <= 1'b0;
      remain <= 6'h0;
      idx <= 4'h0;
      acc <= 128'h0;
      bcd <= 124'h0;
      busy <= 1'b0;
      done <= 1'b0;
      inv_err <= 1'b0;
      res_neg <= 1'b0;
      res_ovf <= 1'b0;
      res_lt <= 1'b0;
      res_eq <= 1'b0;
      result <= 128'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 8'h0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            op <= cmd_op;
            size <= cmd_size;
            sgn <= cmd_signed;
            neg <= cmd_neg;
            bcd <= cmd_bcd;
            acc <= 128'h0;
            idx <= 4'h0;
            mem_addr <= cmd_addr;
            inv_err <= 1'b0;
            res_neg <= 1'b0;
            res_ovf <= 1'b0;
            res_lt <= 1'b0;
            res_eq <= 1'b0;
            result <= 128'h0;
            case (cmd_op)
              `ISF_OP_INT: begin
                if (cmd_size > `ISF_SZ_OCTA) begin
                  inv_err <= 1'b1;
                  done <= 1'b1;
                end else begin
                  remain <= nbytes;
                  busy <= 1'b1;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  state <= ST_RD_INT;
                end
              end
              `ISF_OP_DEC: begin
                if (cmd_len > `ISF_MAX_DIGITS) begin
                  inv_err <= 1'b1;
                  done <= 1'b1;
                end else begin
                  remain <= cmd_len;
                  busy <= 1'b1;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  state <= ST_RD_SIGN;
                end
              end
              `ISF_OP_ENC: begin
                if ((cmd_len > `ISF_MAX_DIGITS) || bcd_bad) begin
                  inv_err <= 1'b1;
                  done <= 1'b1;
                end else begin
                  remain <= cmd_len;
                  busy <= 1'b1;
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_wdata <= cmd_neg ? `ISF_SIGN_MINUS : `ISF_SIGN_PLUS;
                  state <= ST_WR_SIGN;
                end
              end
              `ISF_OP_ARITH: begin
                done <= 1'b1;
                if (cmd_size > `ISF_SZ_LONG) begin
                  inv_err <= 1'b1;
                end else begin
                  result <= {96'h0, ar_sum};
                  res_ovf <= ar_err;
                  res_lt <= ar_lt;
                  res_eq <= ar_eq;
                  res_neg <= cmd_signed & ar_lt;
                end
              end
              default: begin
                inv_err <= 1'b1;
                done <= 1'b1;
              end
            endcase
          end
        end
        ST_RD_INT: begin
          if (mem_ack) begin
            acc <= next_acc_int;
            idx <= idx + 4'h1;
            remain <= remain - 6'h01;
            if (remain == 6'h01) begin
              mem_req <= 1'b0;
              state <= ST_FIN;
            end else begin
              mem_addr <= mem_addr + 32'h1;
            end
          end
        end
        ST_RD_SIGN: begin
          if (mem_ack) begin
            neg <= sign_neg;
            if (!sign_pos && !sign_neg) begin
              mem_req <= 1'b0;
              inv_err <= 1'b1;
              done <= 1'b1;
              busy <= 1'b0;
              state <= ST_IDLE;
            end else if (remain == 6'h00) begin
              mem_req <= 1'b0;
              state <= ST_FIN;
            end else begin
              mem_addr <= mem_addr + 32'h1;
              state <= ST_RD_DIG;
            end
          end
        end
        ST_RD_DIG: begin
          if (mem_ack) begin
            if (!dig_ok) begin
              mem_req <= 1'b0;
              inv_err <= 1'b1;
              done <= 1'b1;
              busy <= 1'b0;
              state <= ST_IDLE;
            end else begin
              acc <= next_acc_dig;
              remain <= remain - 6'h01;
              if (remain == 6'h01) begin
                mem_req <= 1'b0;
                state <= ST_FIN;
              end else begin
                mem_addr <= mem_addr + 32'h1;
              end
            end
          end
        end
        ST_WR_SIGN: begin
          if (mem_ack) begin
            if (remain == 6'h00) begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              state <= ST_FIN;
            end else begin
              mem_addr <= mem_addr + 32'h1;
              mem_wdata <= next_digit;
              state <= ST_WR_DIG;
            end
          end
        end
        ST_WR_DIG: begin
          if (mem_ack) begin
            remain <= remain - 6'h01;
            if (remain == 6'h01) begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              state <= ST_FIN;
            end else begin
              mem_addr <= mem_addr + 32'h1;
              mem_wdata <= next_digit;
            end
          end
        end
        ST_FIN: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= ST_IDLE;
          if (op == `ISF_OP_INT) begin
            result <= next_ext;
            res_neg <= ext_sign;
          end else if (op == `ISF_OP_DEC) begin
            result <= neg ? neg_acc : acc;
            res_neg <= neg;
          end else begin
            res_neg <= neg;
          end
        end
        default: begin
          busy <= 1'b0;
          mem_req <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== design/isf_consts.vh ====
// Purpose: Shared constants for the integer and numeric string format block
// Assumes: Included by design files by bare name
// Notes: Definitions only, no logic
`ifndef ISF_CONSTS_VH
`define ISF_CONSTS_VH

// Command codes
`define ISF_OP_INT 3'h0
`define ISF_OP_DEC 3'h1
`define ISF_OP_ENC 3'h2
`define ISF_OP_ARITH 3'h3

// Operand size codes, bytes = 1 << code
`define ISF_SZ_BYTE 3'h0
`define ISF_SZ_WORD 3'h1
`define ISF_SZ_LONG 3'h2
`define ISF_SZ_QUAD 3'h3
`define ISF_SZ_OCTA 3'h4

// Sign bit positions per size
`define ISF_TOP_BYTE 7'h07
`define ISF_TOP_WORD 7'h0F
`define ISF_TOP_LONG 7'h1F
`define ISF_TOP_QUAD 7'h3F
`define ISF_TOP_OCTA 7'h7F

// Leading sign string encodings
`define ISF_SIGN_PLUS 8'h2B
`define ISF_SIGN_BLANK 8'h20
`define ISF_SIGN_MINUS 8'h2D
`define ISF_DIGIT_LO 8'h30
`define ISF_DIGIT_HI 8'h39
`define ISF_DIGIT_ZONE 4'h3
`define ISF_DIGIT_MAX 4'h9
`define ISF_MAX_DIGITS 6'h1F

`endif

// ==== design/isf_arith.v ====
// Purpose: Add, subtract and compare on byte, word and longword operands
// Assumes: Purely combinational, registered by the caller
// Notes: Operands are extended to 34 bits so one adder serves both views
`timescale 1ns/1ns
`include "isf_consts.vh"

module isf_arith (
  input wire [31:0] a,
  input wire [31:0] b,
  input wire [1:0] size,
  input wire is_signed,
  input wire sub,
  output reg [31:0] sum,
  output reg range_err,
  output reg lt,
  output reg eq
);

  // Sign or zero extension of the low operand bits
  function [33:0] ext34;
    input [31:0] v;
    input [1:0] sz;
    input s;
    begin
      case (sz)
        2'h0: ext34 = {{26{s & v[7]}}, v[7:0]};
        2'h1: ext34 = {{18{s & v[15]}}, v[15:0]};
        default: ext34 = {{2{s & v[31]}}, v[31:0]};
      endcase
    end
  endfunction

  reg [33:0] ea;
  reg [33:0] eb;
  reg [33:0] full;
  reg [33:0] zx;

  // Exact result, then check it fits the chosen view
  always @* begin
    ea = ext34(a, size, is_signed);
    eb = ext34(b, size, is_signed);
    full = sub ? (ea - eb) : (ea + eb);
    zx = ext34(full[31:0], size, 1'b0); // Keeps only the bits of the chosen size
    sum = zx[31:0];
    range_err = (full != ext34(full[31:0], size, is_signed));
    lt = full[33];
    eq = (full == 34'h0);
  end

endmodule

// ==== sim/isf_mem_model.sv ====
// Purpose: Byte memory standing beside the operand format unit
// Assumes: One byte moves per cycle with req and ack both high
// Notes: Slow mode acks every other cycle to stretch transfers
`timescale 1ns/1ns
module isf_mem_model (
  input wire clk,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_wdata,
  output wire mem_ack,
  output wire [7:0] mem_rdata
);
  reg [7:0] mem [0:255];
  reg tog = 1'b0;
  reg [7:0] last = 8'h00;
  // Idle read lines show the inverse of the last byte, so stale data never passes
  assign mem_ack = mem_req & (~slow | tog);
  assign mem_rdata = mem_ack ? mem[mem_addr[7:0]] : ~last;
  // Store writes and remember the last byte shown
  always @(posedge clk) begin
    tog <= ~tog;
    if (mem_ack)
      last <= mem_rdata;
    if (mem_ack && mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule

// ==== sim/isf_format_sva.sv ====
// Purpose: Port checker for the operand format unit
// Assumes: Single clock, async active high reset
// Notes: Bound to every instance of the unit
`timescale 1ns/1ns
module isf_format_sva (
  input wire clk,
  input wire sys_rst,
  input wire busy,
  input wire done,
  input wire inv_err,
  input wire res_eq,
  input wire [127:0] result,
  input wire mem_req,
  input wire mem_ack,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_wdata
);
  reg [6:0] cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_xfer;
    mem_req && mem_ack;
  endsequence
  sequence s_wait;
    mem_req && !mem_ack;
  endsequence
  // Bytes moved by the current command, cleared while idle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cnt <= 7'h00;
    else if (!busy)
      cnt <= 7'h00;
    else if (mem_req && mem_ack)
      cnt <= cnt + 7'h01;
  end
  a_addr_step: assert property (s_xfer ##1 mem_req |-> mem_addr == $past(mem_addr) + 32'h1)
    else $error("address did not step by one");
  a_req_hold: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("transfer changed before ack");
  a_sign_enc: assert property ($rose(mem_req) && mem_we |-> mem_wdata inside {8'h2B, 8'h2D})
    else $error("bad sign byte written");
  a_digit_enc: assert property ($past(mem_req && mem_ack) && mem_req && mem_we |->
    mem_wdata >= 8'h30 && mem_wdata <= 8'h39)
    else $error("bad digit byte written");
  a_err_zero: assert property (done && inv_err |-> result == 128'h0)
    else $error("result not zero on error");
  a_eq_zero: assert property (done && res_eq |-> result == 128'h0)
    else $error("equal flag with nonzero result");
  a_done_fall: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_idle_quiet: assert property (!busy |-> !mem_req)
    else $error("transfer while idle");
  a_byte_budget: assert property (cnt <= 7'h20)
    else $error("too many bytes in one command");
endmodule
bind isf_format isf_format_sva u_isf_format_sva (.clk(clk), .sys_rst(sys_rst), .busy(busy),
  .done(done), .inv_err(inv_err), .res_eq(res_eq), .result(result), .mem_req(mem_req),
  .mem_ack(mem_ack), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

// ==== sim/isf_format_tb_top.sv ====
// Purpose: Self-checking bench for the operand format unit
// Assumes: Inputs move on the falling edge, memory model on the far side
// Notes: Arithmetic and bad command cases are table rows, loads are a loop, the rest are written out
`timescale 1ns/1ns
module isf_format_tb_top;
  typedef struct packed {logic [2:0] sz; logic sg; logic sb; logic [31:0] a; logic [31:0] b;
    logic [31:0] s; logic [2:0] f;} isf_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_signed = 1'b0, cmd_sub = 1'b0, cmd_neg = 1'b0, slow = 1'b0;
  logic [2:0] cmd_op = 3'h0, cmd_size = 3'h0;
  logic [31:0] cmd_addr = 32'h0, cmd_a = 32'h0, cmd_b = 32'h0;
  logic [5:0] cmd_len = 6'h0;
  logic [123:0] cmd_bcd = 124'h0;
  wire busy, done, inv_err, res_neg, res_ovf, res_lt, res_eq, mem_req, mem_we, mem_ack;
  wire [127:0] result;
  wire [31:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata;
  int bad_count = 0, check_count = 0, xfers = 0, i, k;
  logic [127:0] ev;
  string s9;
  logic [5:0] ers [3] = '{6'h28, 6'h05, 6'h1B};
  // Flags are {overflow, below, equal}
  isf_row_t rows [6] = '{
    '{3'h0, 1'b0, 1'b0, 32'hFF, 32'h1, 32'h0, 3'h4},
    '{3'h0, 1'b1, 1'b0, 32'h7F, 32'h1, 32'h80, 3'h4},
    '{3'h1, 1'b1, 1'b1, 32'h0, 32'h1, 32'hFFFF, 3'h2},
    '{3'h1, 1'b0, 1'b1, 32'h5, 32'h5, 32'h0, 3'h1},
    '{3'h2, 1'b0, 1'b1, 32'h0, 32'h1, 32'hFFFFFFFF, 3'h6},
    '{3'h2, 1'b1, 1'b0, 32'h80000000, 32'hFFFFFFFF, 32'h7FFFFFFF, 3'h6}};
  isf_format u_isf_format (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_size(cmd_size), .cmd_signed(cmd_signed), .cmd_sub(cmd_sub), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_neg(cmd_neg), .cmd_bcd(cmd_bcd), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done), .inv_err(inv_err),
    .res_neg(res_neg), .res_ovf(res_ovf), .res_lt(res_lt), .res_eq(res_eq), .result(result),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  isf_mem_model u_isf_mem_model (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // 25 MHz clock
  always #20 clk = ~clk;
  // Count bytes the memory really moved
  always @(posedge clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1)
      xfers++;
  end
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command, then wait for done under a bound; a hang shows as a done mismatch
  task automatic run(input logic [2:0] op, input logic [2:0] sz, input logic [31:0] ad,
    input logic [5:0] ln);
    int n;
    n = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_size = sz;
    cmd_addr = ad;
    cmd_len = ln;
    cmd_valid = 1'b1;
    xfers = 0;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("done", 128'h1, {127'h0, done});
  endtask
  task automatic dec(input string s, input logic [127:0] e, input logic [1:0] en);
    for (int j = 0; j < s.len(); j++)
      u_isf_mem_model.mem[8'h40 + j] = s[j];
    run(3'h1, 3'h0, 32'h40, 6'(s.len() - 1));
    chk("decode value", e, result);
    chk("decode flags", {126'h0, en}, {126'h0, inv_err, res_neg});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    bad_count++;
    conclude;
  end
  initial begin
    for (i = 0; i < 256; i++)
      u_isf_mem_model.mem[i] = 8'hF0 ^ i[7:0];
    repeat (16) @(negedge clk);
    chk("reset state", 128'h0, {busy, done, inv_err, mem_req, result[123:0]});
    sys_rst = 1'b0;
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      {cmd_signed, cmd_sub, cmd_a, cmd_b} = {rows[i].sg, rows[i].sb, rows[i].a, rows[i].b};
      run(3'h3, rows[i].sz, 32'h0, 6'h0);
      chk("arith sum", {96'h0, rows[i].s}, result);
      chk("arith flags", {125'h0, rows[i].f}, {125'h0, res_ovf, res_lt, res_eq});
      chk("arith sign", {127'h0, rows[i].sg & rows[i].f[1]}, {127'h0, res_neg});
    end
    $display("test arith done");
    // Loads from an odd address; every top byte is negative, slow memory on signed ones
    for (i = 0; i < 10; i++) begin
      cmd_signed = i[0];
      slow = i[0];
      run(3'h0, i[3:1], 32'h13, 6'h0);
      ev = 128'h0;
      for (k = (1 << i[3:1]) - 1; k >= 0; k--)
        ev = {ev[119:0], 8'hF0 ^ (8'h13 + k[7:0])};
      if (i[0] && ev[(8 << i[3:1]) - 1])
        ev = ev | ~((128'h1 << (8 << i[3:1])) - 128'h1);
      chk("load value", ev, result);
      chk("load sign", {127'h0, i[0]}, {127'h0, res_neg});
      chk("load bytes", 128'h1 << i[3:1], xfers);
    end
    $display("test load done");
    dec("+123", 128'h7B, 2'h0);
    dec(" 123", 128'h7B, 2'h0);
    dec("-123", 128'h0 - 128'h7B, 2'h1);
    dec("+", 128'h0, 2'h0);
    chk("zero length bytes", 128'h1, xfers);
    s9 = "+";
    ev = 128'h0;
    for (k = 0; k < 31; k++) begin
      s9 = {s9, "9"};
      ev = ev * 128'hA + 128'h9;
    end
    dec(s9, ev, 2'h0);
    chk("long string bytes", 128'h20, xfers);
    dec("+1:3", 128'h0, 2'h2);
    chk("stop at bad digit", 128'h3, xfers);
    dec(",12", 128'h0, 2'h2);
    run(3'h1, 3'h0, 32'h40, 6'h20);
    chk("count too big", 128'h1, {127'h0, inv_err});
    $display("test decode done");
    cmd_neg = 1'b1;
    cmd_bcd = 124'h21;
    run(3'h2, 3'h0, 32'h60, 6'h2);
    chk("encode bytes", 128'h2D3231, {104'h0, u_isf_mem_model.mem[8'h60],
      u_isf_mem_model.mem[8'h61], u_isf_mem_model.mem[8'h62]});
    chk("encode sign flag", 128'h1, {127'h0, res_neg});
    cmd_neg = 1'b0;
    slow = 1'b0;
    run(3'h2, 3'h0, 32'h70, 6'h0);
    chk("encode plus", 128'h2B81, {112'h0, u_isf_mem_model.mem[8'h70],
      u_isf_mem_model.mem[8'h71]});
    cmd_bcd = 124'hA;
    run(3'h2, 3'h0, 32'h78, 6'h1);
    chk("encode bad digit", 128'h1, {127'h0, inv_err});
    for (i = 0; i < 3; i++) begin
      run(ers[i][5:3], ers[i][2:0], 32'h0, 6'h0);
      chk("bad command", 128'h1, {127'h0, inv_err});
    end
    $display("test encode and errors done");
    // Reset in mid command: transfer dropped, unit answers the next command
    cmd_bcd = 124'h0;
    slow = 1'b1;
    @(negedge clk);
    {cmd_op, cmd_addr, cmd_len, cmd_valid} = {3'h2, 32'h80, 6'h1F, 1'b1};
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk("busy before reset", 128'h1, {127'h0, busy});
    sys_rst = 1'b1;
    @(negedge clk);
    chk("mid reset state", 128'h0, {busy, done, inv_err, mem_req, result[123:0]});
    sys_rst = 1'b0;
    dec("+7", 128'h7, 2'h0);
    $display("test mid reset done");
    conclude;
  end
endmodule
